/* File: design/sleep_ctrl_defs.svh */
// Constants for the sleep and power reduction controller.
// Assumes AXI4-Lite byte addressing, 32-bit data, 8-bit registers in low bits.
`ifndef SLEEP_CTRL_DEFS_SVH
`define SLEEP_CTRL_DEFS_SVH

// ==========================================================
// Register byte addresses
`define ADDR_GATE          8'h00
`define ADDR_POWER         8'h35
`define ADDR_INDEX_POWER   8'h35
`define ADDR_POWER_BYTE    8'hD4
`define ADDR_STATUS        8'hD8
`define ADDR_AUX           8'hDC

// ==========================================================
// Field positions, power control register
`define POW_SLEEP_OFF      7
`define POW_SLEEP_EN       5
`define POW_MODE_HI        4
`define POW_MODE_LO        3
`define POW_CHANGE_EN      2

// ==========================================================
// Field positions, clock gate register
`define GATE_RESERVED      4
`define GATE_TIMER_ONE     3
`define GATE_TIMER_ZERO    2
`define GATE_SERIAL        1
`define GATE_CONVERTER     0
`define GATE_WR_MASK       8'h0F

// ==========================================================
// Field positions, auxiliary register
`define AUX_CONV_ON        0
`define AUX_COMP_ON        1
`define AUX_COMP_USES_REF  2
`define AUX_BROWNOUT_ON    3
`define AUX_WATCHDOG_ON    4

// ==========================================================
// Reset values and timing
`define RESET_BYTE         8'h00
`define CHANGE_WINDOW      3'h4
`define SLEEP_OFF_LIFE     3'h3
`define WAKE_HALT          3'h4
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

/* File: design/sleep_ctrl_pkg.sv */
// Types for the sleep and power reduction controller.
// Assumes the defines header is compiled alongside.
package sleep_ctrl_pkg;

  // ==========================================================
  // Sleep mode encodings
  typedef enum logic [1:0] {
    MODE_IDLE     = 2'b00,
    MODE_NOISE    = 2'b01,
    MODE_PWR_DOWN = 2'b10,
    MODE_RESERVED = 2'b11
  } sleep_mode_t;

  // ==========================================================
  // Core state, one-hot
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE  = 3'b100
  } core_state_t;

endpackage : sleep_ctrl_pkg

/* File: design/sleep_power_control.sv */
// Sleep mode, timed detector disable and peripheral clock gating controller.
// Assumes a core that pulses sleep_instr and wake_event, and an AXI4-Lite master.
//
// Function
// [RULE1] Two-bit sleep field picks idle, noise reduction or power-down; fourth is reserved
// [RULE2] SLEEP enters the selected mode only while sleep enable is one
// [RULE3] Off bit is set only by both-ones write then off-only write within four cycles
// [RULE4] Off bit is in effect after three cycles; SLEEP then switches detector off
// [RULE5] Hardware clears the off bit three cycles after it was set; the code keeps it set four cycles, clearing it one cycle after it takes effect
// [RULE6] Gate register top three bits are read-only; bit four reads zero
// [RULE7] Timer one gate bit freezes timer one; clearing it resumes the timer
// [RULE8] Timer zero gate bit freezes timer zero; clearing it resumes the timer
// [RULE9] Serial gate bit stops the serial clock; software re-initialises afterwards
// [RULE10] Converter gate shuts converter down and blocks comparator input mux routing
// [RULE11] Input buffers disabled when I/O and converter clocks both stop, except wake pins
// [RULE12] Enabled converter stays on in sleep; restart marks next conversion extended
// [RULE13] Power-down turns comparator off; reference kept if comparator uses it
// [RULE14] Reference on whenever detector, comparator or converter needs it
// [RULE15] Enabled watchdog and detector stay on in sleep unless timed disable applies
// [RULE16] Software sets sleep enable just before SLEEP and clears it after waking
// [RULE17] Software disables digital buffers of analog pins by the disable register
// [RULE18] Wake by interrupt halts four cycles more before the core resumes
// [RULE19] Software-disabled detector goes off at sleep entry and back on at wake
// [RULE20] SLEEP with the reserved mode leaves the core running
`timescale 1ns/1ps
`include "sleep_ctrl_defs.svh"

module sleep_power_control (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  prepared_read_in,
  input  wire logic        sleep_instr,
  input  wire logic        wake_event,
  output logic             core_halt,
  output logic             clk_cpu_en,
  output logic             clk_io_en,
  output logic             clk_conv_en,
  output logic             osc_en,
  output logic             timer_one_run,
  output logic             timer_zero_run,
  output logic             serial_clk_en,
  output logic             converter_powered,
  output logic             comp_mux_allowed,
  output logic             extended_conversion,
  output logic             comparator_on,
  output logic             reference_on,
  output logic             brownout_on,
  output logic             watchdog_on,
  output logic             input_buf_en,
  output logic             wake_pin_buf_en
);

  // ==========================================================
  // State
  logic [7:0]                gate_reg;
  logic [7:0]                power_reg;
  logic [4:0]                aux_reg;
  logic [2:0]                window_reg;
  logic [2:0]                life_reg;
  logic [2:0]                halt_reg;
  logic                      bod_off_reg;
  logic                      conv_was_off_reg;
  logic                      ext_conv_reg;
  sleep_ctrl_pkg::sleep_mode_t mode_reg;
  sleep_ctrl_pkg::core_state_t state_reg;
  sleep_ctrl_pkg::core_state_t state_next;
  logic                      aw_hold_reg;
  logic                      w_hold_reg;
  logic [7:0]                aw_addr_reg;
  logic [31:0]               w_data_reg;
  logic [3:0]                w_strb_reg;
  logic                      bvalid_reg;
  logic [1:0]                bresp_reg;
  logic                      rvalid_reg;
  logic [31:0]               rdata_reg;
  logic [1:0]                rresp_reg;

  // ==========================================================
  // Bus decode
  wire        wr_fire   = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire        wr_gate   = wr_fire & (aw_addr_reg == `ADDR_GATE) & w_strb_reg[0];
  wire        wr_power  = wr_fire & (aw_addr_reg == `ADDR_POWER_BYTE) & w_strb_reg[0];
  wire        wr_aux    = wr_fire & (aw_addr_reg == `ADDR_AUX) & w_strb_reg[0];
  wire        wr_known  = (aw_addr_reg == `ADDR_GATE) | (aw_addr_reg == `ADDR_POWER_BYTE)
                        | (aw_addr_reg == `ADDR_STATUS) | (aw_addr_reg == `ADDR_AUX);
  wire [7:0]  wbyte     = w_data_reg[7:0];
  wire        rd_fire   = s_axi_arvalid & ~rvalid_reg;
  wire        both_ones = wbyte[`POW_SLEEP_OFF] & wbyte[`POW_CHANGE_EN];
  wire        off_only  = wbyte[`POW_SLEEP_OFF] & ~wbyte[`POW_CHANGE_EN];
  wire        set_off   = wr_power & off_only & (window_reg != 3'h0);              // RULE3
  wire        off_live  = power_reg[`POW_SLEEP_OFF] & (life_reg == 3'h0);          // RULE4
  wire [7:0]  gate_read = {prepared_read_in, 1'b0, gate_reg[3:0]};                // RULE6
  wire [7:0]  status_rd = {3'h0, bod_off_reg, ext_conv_reg, state_reg};
  wire        mode_ok   = power_reg[`POW_MODE_HI:`POW_MODE_LO] != 2'b11;          // RULE20
  wire        go_sleep  = sleep_instr & power_reg[`POW_SLEEP_EN] & mode_ok;       // RULE2
  wire        asleep    = state_reg == sleep_ctrl_pkg::ST_SLEEP;
  wire        pdown     = asleep & (mode_reg == sleep_ctrl_pkg::MODE_PWR_DOWN);   // RULE1

  assign s_axi_awready = ~aw_hold_reg;
  assign s_axi_wready  = ~w_hold_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ==========================================================
  // Write channel capture
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid & ~aw_hold_reg) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid & ~w_hold_reg) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Responses
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `RESP_OKAY;
    end else begin
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= `RESP_OKAY;
        case (s_axi_araddr)
          `ADDR_GATE:       rdata_reg <= {24'h00_0000, gate_read};
          `ADDR_POWER_BYTE: rdata_reg <= {24'h00_0000, power_reg};
          `ADDR_STATUS:     rdata_reg <= {24'h00_0000, status_rd};
          `ADDR_AUX:        rdata_reg <= {27'h000_0000, aux_reg};
          default: begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Registers and timed sequence
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gate_reg   <= `RESET_BYTE;
      power_reg  <= `RESET_BYTE;
      aux_reg    <= 5'h00;
      window_reg <= 3'h0;
      life_reg   <= 3'h0;
    end else begin
      if (wr_gate) gate_reg <= wbyte & `GATE_WR_MASK;                             // RULE6
      if (wr_aux) aux_reg <= wbyte[4:0];
      if (wr_power & both_ones) begin
        window_reg <= `CHANGE_WINDOW;                                              // RULE3
      end else if (window_reg != 3'h0) begin
        window_reg <= window_reg - 3'h1;
      end
      if (wr_power) begin
        power_reg[6:0] <= wbyte[6:0];
      end
      if (set_off) begin
        power_reg[`POW_SLEEP_OFF] <= 1'b1;                                        // RULE3
        life_reg <= `SLEEP_OFF_LIFE;
      end else if (power_reg[`POW_SLEEP_OFF]) begin
        if (life_reg != 3'h0) life_reg <= life_reg - 3'h1;
        else power_reg[`POW_SLEEP_OFF] <= 1'b0;                                   // RULE5
      end
    end
  end

  // ==========================================================
  // Core sleep state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sleep_ctrl_pkg::ST_RUN:   if (go_sleep) state_next = sleep_ctrl_pkg::ST_SLEEP;
      sleep_ctrl_pkg::ST_SLEEP: if (wake_event) state_next = sleep_ctrl_pkg::ST_WAKE;
      sleep_ctrl_pkg::ST_WAKE:  if (halt_reg == 3'h1) state_next = sleep_ctrl_pkg::ST_RUN;
      default:                  state_next = sleep_ctrl_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg        <= sleep_ctrl_pkg::ST_RUN;
      mode_reg         <= sleep_ctrl_pkg::MODE_IDLE;
      halt_reg         <= 3'h0;
      bod_off_reg      <= 1'b0;
      conv_was_off_reg <= 1'b0;
      ext_conv_reg     <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (go_sleep & (state_reg == sleep_ctrl_pkg::ST_RUN)) begin
        mode_reg    <= sleep_ctrl_pkg::sleep_mode_t'(power_reg[`POW_MODE_HI:`POW_MODE_LO]);
        bod_off_reg <= off_live;                                                  // RULE4 RULE19
      end
      if (asleep & wake_event) begin
        halt_reg    <= `WAKE_HALT;                                                // RULE18
        bod_off_reg <= 1'b0;                                                      // RULE19
      end else if (halt_reg != 3'h0) begin
        halt_reg <= halt_reg - 3'h1;
      end
      conv_was_off_reg <= ~converter_powered;
      if (conv_was_off_reg & converter_powered) ext_conv_reg <= 1'b1;             // RULE12
      else if (~aux_reg[`AUX_CONV_ON]) ext_conv_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Clock domains and module enables
  assign core_halt        = state_reg != sleep_ctrl_pkg::ST_RUN;                  // RULE18
  assign clk_cpu_en       = ~core_halt;
  assign clk_io_en        = ~asleep | (mode_reg == sleep_ctrl_pkg::MODE_IDLE);    // RULE1
  assign clk_conv_en      = ~pdown;
  assign osc_en           = ~pdown;
  assign timer_one_run    = clk_io_en & ~gate_reg[`GATE_TIMER_ONE];               // RULE7
  assign timer_zero_run   = clk_io_en & ~gate_reg[`GATE_TIMER_ZERO];              // RULE8
  assign serial_clk_en    = clk_io_en & ~gate_reg[`GATE_SERIAL];                  // RULE9
  assign converter_powered = aux_reg[`AUX_CONV_ON] & ~gate_reg[`GATE_CONVERTER];  // RULE10 RULE12
  assign comp_mux_allowed = ~gate_reg[`GATE_CONVERTER];                           // RULE10
  assign extended_conversion = ext_conv_reg;
  assign comparator_on    = aux_reg[`AUX_COMP_ON] & ~pdown;                       // RULE13
  assign brownout_on      = aux_reg[`AUX_BROWNOUT_ON] & ~bod_off_reg;             // RULE15
  assign watchdog_on      = aux_reg[`AUX_WATCHDOG_ON];                            // RULE15
  assign reference_on     = brownout_on | converter_powered                       // RULE14
                          | (aux_reg[`AUX_COMP_ON] & aux_reg[`AUX_COMP_USES_REF]); // RULE13
  assign input_buf_en     = clk_io_en | clk_conv_en;                              // RULE11
  assign wake_pin_buf_en  = 1'b1;                                                 // RULE11

  // ==========================================================
  // Checks
  chk_sleep_needs_enable: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE2
    (state_reg == sleep_ctrl_pkg::ST_RUN && sleep_instr && !power_reg[`POW_SLEEP_EN])
      |=> state_reg == sleep_ctrl_pkg::ST_RUN)
    else $error("sleep entered without enable");
  chk_reserved_mode_runs: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE20
    (state_reg == sleep_ctrl_pkg::ST_RUN && sleep_instr
      && power_reg[`POW_MODE_HI:`POW_MODE_LO] == 2'b11) |=> !core_halt)
    else $error("reserved mode halted core");
  chk_off_self_clear: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE5
    set_off |=> power_reg[`POW_SLEEP_OFF] [*4] ##1 !power_reg[`POW_SLEEP_OFF])
    else $error("off bit lifetime wrong");
  chk_off_needs_seq: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE3
    $rose(power_reg[`POW_SLEEP_OFF]) |-> $past(window_reg) != 3'h0)
    else $error("off bit set without sequence");
  chk_off_effect_delay: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE4
    set_off |=> !off_live ##1 !off_live ##1 !off_live ##1 off_live)
    else $error("off bit effect timing wrong");
  chk_wake_halt_four: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE18
    (asleep && wake_event) |=> core_halt [*4] ##1 !core_halt)
    else $error("wake halt not four cycles");
  chk_gate_reserved_zero: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE6
    rvalid_reg && $past(rd_fire && s_axi_araddr == `ADDR_GATE) |-> !rdata_reg[`GATE_RESERVED])
    else $error("reserved gate bit read one");
  chk_timer_freeze: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE7
    gate_reg[`GATE_TIMER_ONE] |-> !timer_one_run && !timer_zero_run == gate_reg[`GATE_TIMER_ZERO]
      || !clk_io_en)
    else $error("timer gating wrong");
  chk_pdown_comparator: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE13
    pdown |-> !comparator_on && !input_buf_en)
    else $error("power-down left comparator or buffers on");

endmodule : sleep_power_control

/* File: verification/core_model.sv */
// Processor core model: issues SLEEP pulses and wake-up interrupts.
// Assumes a bench that holds each request for one cycle, and the
// controller's core_halt output.
`timescale 1ns/1ps

module core_model (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic core_halt,
  input  wire logic sleep_req,
  input  wire logic wake_req,
  output logic      sleep_instr,
  output logic      wake_event
);
  // ==========================================================
  // Instruction issue and interrupt wake-up
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sleep_instr <= 1'b0;
      wake_event  <= 1'b0;
    end else begin
      sleep_instr <= sleep_req & ~core_halt;
      wake_event  <= wake_req & core_halt;
    end
  end
endmodule : core_model

/* File: verification/sleep_and_power_reduction_control_test.sv */
// Self-checking bench for the sleep and clock gating controller.
// Assumes the design files and the defines header on the include path.
`timescale 1ns/1ps
`include "sleep_ctrl_defs.svh"

module sleep_and_power_reduction_control_test;
  logic        clk_sys = 1'b0;
  logic        resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, sleep_instr, wake_event, sleep_req, wake_req, core_halt;
  logic        clk_cpu_en, clk_io_en, clk_conv_en, osc_en, timer_one_run, timer_zero_run;
  logic        serial_clk_en, converter_powered, comp_mux_allowed, extended_conversion;
  logic        comparator_on, reference_on, brownout_on, watchdog_on, input_buf_en;
  logic        wake_pin_buf_en;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [31:0] st = 32'h0001_24B1;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, m;
  logic [2:0]  prepared_read_in;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  int          n_fail = 0;
  int          n_tests = 0;
  int          hits, n;

  sleep_power_control dut (.clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .prepared_read_in, .sleep_instr, .wake_event, .core_halt,
    .clk_cpu_en, .clk_io_en, .clk_conv_en, .osc_en, .timer_one_run, .timer_zero_run,
    .serial_clk_en, .converter_powered, .comp_mux_allowed, .extended_conversion,
    .comparator_on, .reference_on, .brownout_on, .watchdog_on, .input_buf_en,
    .wake_pin_buf_en);
  core_model core (.clk_sys, .resetn, .core_halt, .sleep_req, .wake_req, .sleep_instr,
    .wake_event);

  always #12.5 clk_sys = ~clk_sys;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction : rnd

  function automatic logic [33:0] ok8(input logic [7:0] b);
    return {26'h000_0000, b};
  endfunction : ok8

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic timeout;
    n_fail++;
    $display("[FAIL] %0t wait limit reached", $time);
    conclude();
  endtask : timeout

  // ==========================================================
  // Bus master, entered at a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] r);
    int i;
    bq.push_back(r);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) timeout();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int i;
    rq.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) timeout();
  endtask : rd

  always @(posedge clk_sys) begin
    if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end

  // ==========================================================
  // Core events
  task automatic pulse_sleep;
    sleep_req <= 1'b1;
    @(posedge clk_sys);
    sleep_req <= 1'b0;
  endtask : pulse_sleep

  task automatic wait_halt(input logic v);
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge clk_sys);
      if (core_halt === v) break;
    end
    if (i == 20) timeout();
    @(posedge clk_sys);
  endtask : wait_halt

  task automatic wake(output int c);
    int i;
    wake_req <= 1'b1;
    @(posedge clk_sys);
    wake_req <= 1'b0;
    @(posedge clk_sys);
    c = 0;
    for (i = 0; i < 20; i++) begin
      @(negedge clk_sys);
      if (core_halt !== 1'b1) break;
      c++;
    end
    if (i == 20) timeout();
    @(posedge clk_sys);
  endtask : wake

  initial begin
    repeat (20000) @(posedge clk_sys);
    timeout();
  end

  // ==========================================================
  // Scenarios
  initial begin
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {sleep_req, wake_req} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    d = rnd();
    prepared_read_in = d[2:0];
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(`ADDR_GATE, ok8({prepared_read_in, 5'h00}));
    rd(`ADDR_POWER_BYTE, ok8(8'h00));
    rd(8'h10, {2'b10, 32'h0000_0000});
    wr(8'h10, 32'h0000_00FF, 4'hF, 2'b10);
    wr(`ADDR_AUX, 32'h0000_001F, 4'hF, 2'b00);
    for (int k = 0; k < 4; k++) begin
      d = rnd();
      prepared_read_in <= d[10:8];
      wr(`ADDR_GATE, d, 4'hF, 2'b00);
      rd(`ADDR_GATE, ok8({d[10:8], 1'b0, d[3:0]}));
      @(negedge clk_sys);
      check(timer_one_run, !d[3]);
      check(timer_zero_run, !d[2]);
      check(serial_clk_en, !d[1]);
      check({comp_mux_allowed, converter_powered}, {2{~d[0]}});
      @(posedge clk_sys);
    end
    wr(`ADDR_GATE, 32'h0000_000F, 4'h0, 2'b00);
    rd(`ADDR_GATE, ok8({d[10:8], 1'b0, d[3:0]}));
    wr(`ADDR_GATE, 32'h0000_0001, 4'hF, 2'b00);
    wr(`ADDR_GATE, 32'h0000_0000, 4'hF, 2'b00);
    @(negedge clk_sys);
    check(extended_conversion, 1'b1);
    @(posedge clk_sys);
    wr(`ADDR_AUX, 32'h0000_0002, 4'hF, 2'b00);
    @(negedge clk_sys);
    check({extended_conversion, converter_powered, reference_on}, 3'b000);
    @(posedge clk_sys);
    wr(`ADDR_AUX, 32'h0000_001F, 4'hF, 2'b00);
    for (int k = 0; k < 4; k++) begin
      m = k[1:0];
      wr(`ADDR_POWER_BYTE, {24'h00_0000, 3'b001, m, 3'b000}, 4'hF, 2'b00);
      pulse_sleep();
      if (m == 2'b11) begin
        repeat (3) @(negedge clk_sys);
        check(core_halt, 1'b0);
        @(posedge clk_sys);
      end else begin
        wait_halt(1'b1);
        check({clk_cpu_en, clk_io_en}, {1'b0, m == 2'b00});
        check({clk_conv_en, osc_en, input_buf_en}, {3{m != 2'b10}});
        check(wake_pin_buf_en, 1'b1);
        check(comparator_on, m != 2'b10);
        check({converter_powered, reference_on}, 2'b11);
        check({brownout_on, watchdog_on}, 2'b11);
        wake(n);
        check(n, 4);
      end
      wr(`ADDR_POWER_BYTE, 32'h0000_0000, 4'hF, 2'b00);
    end
    wr(`ADDR_POWER_BYTE, 32'h0000_0010, 4'hF, 2'b00);
    pulse_sleep();
    repeat (3) @(negedge clk_sys);
    check(core_halt, 1'b0);
    @(posedge clk_sys);
    for (int ok = 0; ok < 2; ok++) begin
      hits = 0;
      for (int w = 0; w < 6; w++) begin
        wr(`ADDR_POWER_BYTE, ok ? 32'h0000_0084 : 32'h0000_0080, 4'hF, 2'b00);
        wr(`ADDR_POWER_BYTE, 32'h0000_00B0, 4'hF, 2'b00);
        repeat (w) @(posedge clk_sys);
        pulse_sleep();
        wait_halt(1'b1);
        if (brownout_on === 1'b0) hits++;
        wake(n);
        @(negedge clk_sys);
        check(brownout_on, 1'b1);
        @(posedge clk_sys);
        wr(`ADDR_POWER_BYTE, 32'h0000_0000, 4'hF, 2'b00);
      end
      check(hits, ok);
    end
    wr(`ADDR_POWER_BYTE, 32'h0000_0084, 4'hF, 2'b00);
    wr(`ADDR_POWER_BYTE, 32'h0000_00B0, 4'hF, 2'b00);
    repeat (4) @(posedge clk_sys);
    rd(`ADDR_POWER_BYTE, ok8(8'h30));
    conclude();
  end
endmodule : sleep_and_power_reduction_control_test
